// [rtl/dcd_device.sv]
// Device-side command decoder with power state and ODT transition tracking.
//
// Function
// - Decode commands from pins at clock edge.
// - All four low, CKE high: mode set.
// - Bank bits select target bank.
// - RAS high, CAS/WE low: write command.
// - A12 picks chop or eight in on-the-fly.
// - Read decodes as write with WE high.
// - A10 high requests auto-precharge after burst.
// - Started bursts always run to completion.
// - NOP does not end running operations.
// - Controller idles with no-operations.
// - CS high is deselect, same as NOP.
// - Refresh with CKE falling enters self-refresh.
// - CKE fall/rise enters/exits power-down, no refresh.
// - Active-low reset is asynchronous only.
// - ODT ignored by decode; off in self-refresh.
// - Controller waits 512 cycles after self-refresh exit before write.
// - Entry-then-exit overlap keeps RTT uncertain.
// - Exit-then-entry overlap keeps RTT uncertain.
// - Controller drives valid inputs to defined levels.
// - Entry period: starts at entry, ends after disable delay.
// - Exit period: lead before, ends after lock delay.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dcd_device
   import dcd_pkg::*;
#(
   parameter int WL = WL_DEF,
   parameter int CPDED = CPDED_DEF,
   parameter int XPDLL = XPDLL_DEF
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Pins from the controller.
   dcd_if.dev pins,
   // Decoded command.
   output logic cmd_vld_q,
   output dcd_cmd_t cmd_q,
   output logic [BA_W-1:0] bank_q,
   output logic [ADDR_W-1:0] addr_q,
   output logic [COL_W-1:0] col_q,
   output logic auto_pre_q,
   output logic chop_q,
   // Mode, burst and power state.
   input wire logic otf_en,
   output logic burst_busy_q,
   output dcd_state_t state_q,
   output logic rtt_on_q,
   output logic rtt_uncertain_q
);
   localparam int LEAD = WL - 1;
   localparam int TW = 8;

   logic cke_prev_q;
   logic cs_n_d;
   logic [3:0] pins_v;
   dcd_cmd_t cmd_d;
   logic [3:0] burst_cnt_q;
   logic [TW-1:0] end_cnt_q;
   logic [TW-1:0] lead_cnt_q;
   logic rst_async;

   assign rst_async = sys_rst | ~pins.reset_n;

   // CS high masks RAS, CAS and WE; CKE is still decoded.
   assign cs_n_d = pins.cs_n;
   assign pins_v = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

   // Decode from sampled pins, ODT not used.
   always_comb begin
      cmd_d = DCD_CMD_ILL;
      if (state_q != DCD_ST_IDLE) begin
         // Exit with CKE rising under NOP or deselect.
         if (pins.cke && (cs_n_d || pins_v[2:0] == NOP_PINS[2:0])) begin
            cmd_d = (state_q == DCD_ST_SR) ? DCD_CMD_SRX : DCD_CMD_PDX;
         end else begin
            cmd_d = DCD_CMD_NONE;
         end
      end else if (!cke_prev_q) begin
         cmd_d = DCD_CMD_NONE;
      end else if (!pins.cke) begin
         // Power-down entry under NOP or deselect.
         if (cs_n_d || pins_v[2:0] == NOP_PINS[2:0]) begin
            cmd_d = DCD_CMD_PDE;
         end else if (pins_v == 4'h1) begin
            cmd_d = DCD_CMD_SRE;
         end
      end else if (cs_n_d) begin
         cmd_d = DCD_CMD_NOP;
      end else begin
         case (pins_v[2:0])
            3'h0: cmd_d = DCD_CMD_MRS;
            3'h1: cmd_d = DCD_CMD_REF;
            3'h2: cmd_d = pins.addr[AP_BIT] ? DCD_CMD_PREA : DCD_CMD_PRE;
            3'h3: cmd_d = DCD_CMD_ACT;
            3'h4: cmd_d = DCD_CMD_WR;
            3'h5: cmd_d = DCD_CMD_RD;
            3'h6: cmd_d = pins.addr[AP_BIT] ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
            3'h7: cmd_d = DCD_CMD_NOP;
            default: cmd_d = DCD_CMD_ILL;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= pins.cke;
      end
   end

   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         cmd_vld_q <= 1'b0;
         cmd_q <= DCD_CMD_NONE;
         bank_q <= '0;
         addr_q <= '0;
         col_q <= '0;
         auto_pre_q <= 1'b0;
         chop_q <= 1'b0;
      end else begin
         cmd_vld_q <= (cmd_d != DCD_CMD_NONE);
         cmd_q <= cmd_d;
         // Bank bits carry bank or mode register.
         bank_q <= pins.ba;
         addr_q <= pins.addr;
         col_q <= {pins.addr[11], pins.addr[9:0]};
         auto_pre_q <= pins.addr[AP_BIT];
         // Low A12 in on-the-fly mode chops.
         chop_q <= otf_en & ~pins.addr[BC_BIT];
      end
   end

   // Bursts run out; NOP and new commands never cut them.
   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         burst_cnt_q <= '0;
         burst_busy_q <= 1'b0;
      end else if (burst_cnt_q == 4'h0 &&
            (cmd_d == DCD_CMD_WR || cmd_d == DCD_CMD_RD)) begin
         burst_cnt_q <= (otf_en && !pins.addr[BC_BIT]) ? 4'(BURST_BC4) :
            4'(BURST_BL8);
         burst_busy_q <= 1'b1;
      end else if (burst_cnt_q != 4'h0) begin
         burst_cnt_q <= burst_cnt_q - 4'h1;
         burst_busy_q <= (burst_cnt_q != 4'h1);
      end
   end

   // Power state; no refresh while powered down.
   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         state_q <= DCD_ST_IDLE;
      end else begin
         case (cmd_d)
            DCD_CMD_PDE: state_q <= DCD_ST_PD;
            DCD_CMD_SRE: state_q <= DCD_ST_SR;
            DCD_CMD_PDX: state_q <= DCD_ST_IDLE;
            DCD_CMD_SRX: state_q <= DCD_ST_IDLE;
            default: state_q <= state_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         rtt_on_q <= 1'b0;
      end else begin
         rtt_on_q <= pins.odt && cmd_d != DCD_CMD_SRE && state_q != DCD_ST_SR;
      end
   end

   // Lead window opens when the controller holds CKE steady
   // for LEAD cycles ahead of an edge; track the last edge age.
   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         lead_cnt_q <= '0;
      end else if (pins.cke != cke_prev_q) begin
         lead_cnt_q <= '0;
      end else if (lead_cnt_q != {TW{1'b1}}) begin
         lead_cnt_q <= lead_cnt_q + 1'b1;
      end
   end

   // Period ends CPDED after entry or XPDLL after exit.
   // Overlap stretches to the later end.
   always_ff @(posedge clk_sys or posedge rst_async) begin
      if (rst_async) begin
         end_cnt_q <= '0;
         rtt_uncertain_q <= 1'b0;
      end else begin
         if (cmd_d == DCD_CMD_PDE && end_cnt_q < TW'(CPDED)) begin
            end_cnt_q <= TW'(CPDED);
         end else if (cmd_d == DCD_CMD_PDX && end_cnt_q < TW'(XPDLL)) begin
            end_cnt_q <= TW'(XPDLL);
         end else if (end_cnt_q != '0) begin
            end_cnt_q <= end_cnt_q - 1'b1;
         end
         rtt_uncertain_q <= (cmd_d == DCD_CMD_PDE) ||
            (cmd_d == DCD_CMD_PDX) || (end_cnt_q > TW'(1)) ||
            (state_q == DCD_ST_PD && lead_cnt_q >= TW'(LEAD));
      end
   end
endmodule : dcd_device
`default_nettype wire

// [rtl/dcd_pkg.sv]
// Shared constants and types for the command decoder and its controller.
package dcd_pkg;
   localparam int BA_W = 3;
   localparam int ADDR_W = 16;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam int COL_W = 11;
   // Lead time before a CKE edge is write latency minus one.
   localparam int WL_DEF = 5;
   localparam int CPDED_DEF = 1;
   localparam int XPDLL_DEF = 10;
   localparam int SRX_WR_GAP = 512;
   localparam int BURST_BL8 = 4;
   localparam int BURST_BC4 = 2;
   localparam logic [3:0] NOP_PINS = 4'h7;

   typedef enum logic [3:0] {
      DCD_CMD_NONE = 4'h0,
      DCD_CMD_MRS = 4'h1,
      DCD_CMD_REF = 4'h2,
      DCD_CMD_SRE = 4'h3,
      DCD_CMD_SRX = 4'h4,
      DCD_CMD_PRE = 4'h5,
      DCD_CMD_PREA = 4'h6,
      DCD_CMD_ACT = 4'h7,
      DCD_CMD_WR = 4'h8,
      DCD_CMD_RD = 4'h9,
      DCD_CMD_NOP = 4'ha,
      DCD_CMD_PDE = 4'hb,
      DCD_CMD_PDX = 4'hc,
      DCD_CMD_ZQCL = 4'hd,
      DCD_CMD_ZQCS = 4'he,
      DCD_CMD_ILL = 4'hf
   } dcd_cmd_t;

   typedef enum logic [1:0] {
      DCD_ST_IDLE = 2'h0,
      DCD_ST_PD = 2'h1,
      DCD_ST_SR = 2'h2
   } dcd_state_t;
endpackage : dcd_pkg

// [rtl/dcd_if.sv]
// Command and address pins between controller and device decoder.
`timescale 1ns/100ps
`default_nettype none
interface dcd_if;
   import dcd_pkg::*;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic cke;
   logic odt;
   logic reset_n;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, reset_n, ba,
      addr);
   modport dev (input cs_n, ras_n, cas_n, we_n, cke, odt, reset_n, ba, addr);
endinterface : dcd_if
`default_nettype wire

// [rtl/dcd_ctrl.sv]
// Controller end: drives command pins from a simple user request port.
`timescale 1ns/100ps
`default_nettype none
module dcd_ctrl
   import dcd_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // User request.
   input wire logic req_vld,
   input wire dcd_cmd_t req_cmd,
   input wire logic [BA_W-1:0] req_ba,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_odt,
   output logic req_rdy_q,
   // Pins to the device.
   dcd_if.ctrl pins
);
   logic [9:0] srx_cnt_q;
   logic low_pwr_q;
   logic wr_block;
   logic take;
   logic enter_lp;
   logic leave_lp;

   // Writes held 512 cycles after self-refresh exit.
   assign wr_block = (srx_cnt_q != 10'h0) && req_cmd == DCD_CMD_WR;
   assign take = req_vld && req_rdy_q && !wr_block;
   assign enter_lp = take &&
      (req_cmd == DCD_CMD_SRE || req_cmd == DCD_CMD_PDE);
   assign leave_lp = take &&
      (req_cmd == DCD_CMD_SRX || req_cmd == DCD_CMD_PDX);

   // Low power lasts from an entry to its exit request.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         low_pwr_q <= 1'b0;
      end else if (enter_lp) begin
         low_pwr_q <= 1'b1;
      end else if (leave_lp) begin
         low_pwr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         srx_cnt_q <= '0;
      end else if (req_vld && req_rdy_q && req_cmd == DCD_CMD_SRX) begin
         srx_cnt_q <= 10'(SRX_WR_GAP);
      end else if (srx_cnt_q != 10'h0) begin
         srx_cnt_q <= srx_cnt_q - 10'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         req_rdy_q <= 1'b0;
      end else begin
         req_rdy_q <= 1'b1;
      end
   end

   // Idle cycles drive a NOP with defined levels.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pins.cs_n <= 1'b0;
         {pins.ras_n, pins.cas_n, pins.we_n} <= NOP_PINS[2:0];
         pins.cke <= 1'b0;
         pins.odt <= 1'b0;
         pins.ba <= '0;
         pins.addr <= '0;
      end else begin
         pins.cs_n <= 1'b0;
         {pins.ras_n, pins.cas_n, pins.we_n} <= NOP_PINS[2:0];
         pins.odt <= req_odt;
         // Entries drop CKE under refresh or NOP pins.
         pins.cke <= !enter_lp && (leave_lp || !low_pwr_q);
         if (take) begin
            pins.ba <= req_ba;
            pins.addr <= req_addr;
            case (req_cmd)
               DCD_CMD_MRS: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h0;
               DCD_CMD_REF: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h1;
               DCD_CMD_SRE: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h1;
               // A10 picks one bank or all banks.
               DCD_CMD_PRE: begin
                  {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h2;
                  pins.addr[AP_BIT] <= 1'b0;
               end
               DCD_CMD_PREA: begin
                  {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h2;
                  pins.addr[AP_BIT] <= 1'b1;
               end
               DCD_CMD_ACT: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h3;
               DCD_CMD_WR: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h4;
               DCD_CMD_RD: {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h5;
               // A10 picks long or short calibration.
               DCD_CMD_ZQCL: begin
                  {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h6;
                  pins.addr[AP_BIT] <= 1'b1;
               end
               DCD_CMD_ZQCS: begin
                  {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h6;
                  pins.addr[AP_BIT] <= 1'b0;
               end
               // A requested NOP goes out as a deselect.
               DCD_CMD_NOP: pins.cs_n <= 1'b1;
               default: pins.cs_n <= 1'b0;
            endcase
         end
      end
   end

   // Reset pin held high in operation.
   always_ff @(posedge clk_sys) begin
      pins.reset_n <= ~sys_rst;
   end
endmodule : dcd_ctrl
`default_nettype wire

// [tb/dcd_monitor.sv]
// Assertions on the command pins and the decoder outputs.
`timescale 1ns/100ps
`default_nettype none
module dcd_monitor
   import dcd_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Command pins.
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [BA_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   // Decoder side.
   input wire logic otf_en,
   input wire dcd_cmd_t cmd_q,
   input wire logic [BA_W-1:0] bank_q,
   input wire logic chop_q,
   input wire logic burst_busy_q,
   input wire dcd_state_t state_q,
   input wire logic rtt_on_q
);
   logic cke_q;
   logic sel;
   logic rw;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   assign sel = cke && cke_q && !cs_n;
   assign rw = sel && ras_n && !cas_n;
   always_ff @(posedge clk_sys) begin
      cke_q <= sys_rst ? 1'b0 : cke;
   end
   a_mode_set: assert property (
      sel && !ras_n && !cas_n && !we_n |=> cmd_q == DCD_CMD_MRS
      && bank_q == $past(ba)) else $error("mode set not decoded");
   a_write_decode: assert property (
      rw && !we_n |=> cmd_q == DCD_CMD_WR && bank_q == $past(ba))
      else $error("write not decoded");
   a_read_decode: assert property (
      rw && we_n |=> cmd_q == DCD_CMD_RD) else $error("read not decoded");
   a_chop_select: assert property (
      rw |=> chop_q == $past(otf_en && !addr[BC_BIT]))
      else $error("burst chop wrong");
   a_burst_full: assert property (
      $rose(burst_busy_q) && !chop_q |-> burst_busy_q[*4] ##1 !burst_busy_q)
      else $error("burst length wrong");
   a_self_ref_entry: assert property (
      cke_q && !cke && !cs_n && !ras_n && !cas_n && we_n
      |=> state_q == DCD_ST_SR) else $error("self-refresh not entered");
   a_pd_entry: assert property (
      cke_q && !cke && (cs_n || (ras_n && cas_n && we_n))
      && state_q == DCD_ST_IDLE |=> state_q == DCD_ST_PD)
      else $error("power-down not entered");
   a_rtt_sr_off: assert property (
      state_q == DCD_ST_SR && $past(state_q) == DCD_ST_SR |-> !rtt_on_q)
      else $error("termination on in self-refresh");
   a_deselect_nop: assert property (
      cke && cke_q && cs_n && state_q == DCD_ST_IDLE
      |=> cmd_q == DCD_CMD_NOP) else $error("deselect not decoded as NOP");
   c_self_ref: cover property (state_q == DCD_ST_SR);
   c_auto_pre: cover property (rw && addr[AP_BIT]);
   c_pd_exit: cover property (state_q == DCD_ST_PD ##1 state_q == DCD_ST_IDLE);
endmodule : dcd_monitor
`default_nettype wire

// [tb/tb_top.sv]
// Bench driving the controller request port and checking the decoder.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import dcd_pkg::*;
;
   logic clk_sys;
   logic sys_rst;
   logic req_vld;
   dcd_cmd_t req_cmd;
   logic [BA_W-1:0] req_ba;
   logic [ADDR_W-1:0] req_addr;
   logic req_odt;
   logic req_rdy_q;
   logic otf_en;
   logic cmd_vld_q;
   dcd_cmd_t cmd_q;
   logic [BA_W-1:0] bank_q;
   logic [ADDR_W-1:0] addr_q;
   logic [COL_W-1:0] col_q;
   logic auto_pre_q;
   logic chop_q;
   logic burst_busy_q;
   dcd_state_t state_q;
   logic rtt_on_q;
   logic rtt_unc_q;
   int fail_count;
   int checked;
   dcd_cmd_t cl [8] = '{DCD_CMD_MRS, DCD_CMD_ACT, DCD_CMD_PRE, DCD_CMD_PREA,
      DCD_CMD_REF, DCD_CMD_ZQCL, DCD_CMD_ZQCS, DCD_CMD_NOP};
   logic [15:0] al [8] = '{16'h0123, 16'h1234, 16'h0000, 16'h0400, 16'h0000,
      16'h0400, 16'h0000, 16'h0000};
   dcd_if pins ();
   dcd_ctrl i_dcd_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .req_vld(req_vld), .req_cmd(req_cmd), .req_ba(req_ba),
      .req_addr(req_addr), .req_odt(req_odt), .req_rdy_q(req_rdy_q),
      .pins(pins));
   dcd_device i_dcd_device (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .pins(pins), .cmd_vld_q(cmd_vld_q), .cmd_q(cmd_q), .bank_q(bank_q),
      .addr_q(addr_q), .col_q(col_q), .auto_pre_q(auto_pre_q),
      .chop_q(chop_q), .otf_en(otf_en), .burst_busy_q(burst_busy_q),
      .state_q(state_q), .rtt_on_q(rtt_on_q), .rtt_uncertain_q(rtt_unc_q));
   dcd_monitor i_dcd_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
      .we_n(pins.we_n), .cke(pins.cke), .ba(pins.ba), .addr(pins.addr),
      .otf_en(otf_en), .cmd_q(cmd_q), .bank_q(bank_q), .chop_q(chop_q),
      .burst_busy_q(burst_busy_q), .state_q(state_q), .rtt_on_q(rtt_on_q));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Request is held until req_rdy_q is seen, then decoded result is settled.
   task automatic send(input dcd_cmd_t c, input logic [2:0] b,
      input logic [15:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_vld <= 1'b1;
      req_cmd <= c;
      req_ba <= b;
      req_addr <= a;
      @(negedge clk_sys);
      while (req_rdy_q !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 100) begin
         fail_count++;
         $display("[ERR] %0t request never taken", $time);
      end
      @(posedge clk_sys);
      req_vld <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : send
   task automatic final_report();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #50000;
      fail_count++;
      final_report();
   end
   initial begin
      fail_count = 0;
      checked = 0;
      sys_rst = 1'b1;
      req_vld = 1'b0;
      req_cmd = DCD_CMD_NOP;
      req_ba = 3'h0;
      req_addr = 16'h0;
      req_odt = 1'b0;
      otf_en = 1'b0;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         send(cl[i], 3'(i), al[i]);
         chk(16'(cmd_q), 16'(cl[i]));
         chk(16'(cmd_vld_q), 16'h1);
         chk(addr_q, al[i]);
         if (i < 3) chk(16'(bank_q), 16'(i));
      end
      for (int k = 0; k < 16; k++) begin
         otf_en <= k[3];
         send(k[0] ? DCD_CMD_RD : DCD_CMD_WR, 3'(k),
            {3'h0, k[2], 1'b1, k[1], 10'h2a5});
         chk(16'(cmd_q), 16'(k[0] ? DCD_CMD_RD : DCD_CMD_WR));
         chk(16'(col_q), 16'h06a5);
         chk(16'(auto_pre_q), 16'(k[1]));
         chk(16'(chop_q), 16'(k[3] & ~k[2]));
         repeat (4) @(posedge clk_sys);
      end
      send(DCD_CMD_PDE, 3'h0, 16'h0);
      chk(16'(state_q), 16'(DCD_ST_PD));
      repeat (8) @(posedge clk_sys);
      send(DCD_CMD_PDX, 3'h0, 16'h0);
      chk(16'(state_q), 16'(DCD_ST_IDLE));
      chk(16'(rtt_unc_q), 16'h1);
      send(DCD_CMD_PDE, 3'h0, 16'h0);
      chk(16'(rtt_unc_q), 16'h1);
      send(DCD_CMD_PDX, 3'h0, 16'h0);
      chk(16'(rtt_unc_q), 16'h1);
      repeat (XPDLL_DEF + 8) @(posedge clk_sys);
      chk(16'(rtt_unc_q), 16'h0);
      req_odt <= 1'b1;
      send(DCD_CMD_SRE, 3'h0, 16'h0);
      chk(16'(state_q), 16'(DCD_ST_SR));
      @(negedge clk_sys);
      chk(16'(rtt_on_q), 16'h0);
      send(DCD_CMD_SRX, 3'h0, 16'h0);
      chk(16'(state_q), 16'(DCD_ST_IDLE));
      send(DCD_CMD_WR, 3'h1, 16'h0);
      chk(16'(cmd_q == DCD_CMD_WR), 16'h0);
      chk(16'(rtt_on_q), 16'h1);
      repeat (SRX_WR_GAP) @(posedge clk_sys);
      send(DCD_CMD_WR, 3'h1, 16'h0);
      chk(16'(cmd_q), 16'(DCD_CMD_WR));
      send(DCD_CMD_PDE, 3'h0, 16'h0);
      chk(16'(state_q), 16'(DCD_ST_PD));
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(16'(pins.reset_n), 16'h0);
      chk(16'(state_q), 16'(DCD_ST_IDLE));
      final_report();
   end
endmodule : tb_top
`default_nettype wire
